// ### core/brc_pkg.sv
package brc_pkg;

  // Register offsets on the serial control interface
  localparam logic [7:0] CONFIG_OFS  = 8'h01;
  localparam logic [7:0] VOUT_OFS    = 8'h03;
  localparam logic [7:0] LIMIT_OFS   = 8'h04;
  localparam logic [7:0] STATUS_OFS  = 8'h05;

  // Reset values
  localparam logic [7:0] CONFIG_RST  = 8'h09;
  localparam logic [4:0] VOUT_RST    = 5'h0B;
  localparam logic       LIMOFF_RST  = 1'b0;
  localparam logic       SOFT_RST    = 1'b1;
  localparam logic [3:0] LEVEL_RST   = 4'hD;
  localparam logic [7:0] READ_ZERO   = 8'h00;

  // Field positions and widths
  localparam int VOUT_W     = 5;
  localparam int LEVEL_W    = 4;
  localparam int LIMOFF_BIT = 5;
  localparam int SOFT_BIT   = 4;
  localparam int OPER_LSB   = 5;
  localparam int OPER_MSB   = 6;

  // Status bit positions
  localparam int ST_THERMAL = 7;
  localparam int ST_HOT     = 6;
  localparam int ST_MODUL   = 5;
  localparam int ST_CONV    = 4;
  localparam int ST_BYPLIM  = 3;
  localparam int ST_BSTLIM  = 2;
  localparam int ST_FAULT   = 1;
  localparam int ST_RANGE   = 0;

  // Operation field code that forces pass-through
  localparam logic [1:0] OPER_FORCE_BYPASS = 2'h2;

  // Current figures in mA
  localparam int MA_W = 13;
  localparam logic [12:0] MA_BASE   = 13'h05DC; // 1500 mA at code 1000
  localparam logic [12:0] MA_STEP   = 13'h01F4; // 500 mA per code
  localparam logic [12:0] MA_SOFT   = 13'h04E2; // 1250 mA soft-start clamp
  localparam logic [12:0] MA_DEFLT  = 13'h0FA0; // 4000 mA

  // Boost limit qualification time
  localparam int CLK_HZ         = 50_000_000;
  localparam int BOOST_LIM_US   = 1500;
  localparam int BOOST_LIM_CYC  = (CLK_HZ / 1_000_000) * BOOST_LIM_US;

endpackage : brc_pkg

// ### core/brc_sync.sv
`timescale 1ns/1ps
// Three-stage synchroniser per bit; output moves once stages two
// and three agree, so a single metastable sample never counts.
module brc_sync #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Asynchronous inputs and their clean copies
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] sync_out
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_bit
      logic s1;
      logic s2;
      logic s3;
      // Stage one feeds only stage two
      always_ff @(posedge clk) begin
        if (rst) begin
          s1          <= 1'b0;
          s2          <= 1'b0;
          s3          <= 1'b0;
          sync_out[i] <= 1'b0;
        end else begin
          s1 <= async_in[i];
          s2 <= s1;
          s3 <= s2;
          if (s2 == s3) begin
            sync_out[i] <= s3;
          end
        end
      end
    end
  endgenerate

endmodule : brc_sync

// ### core/brc_sticky.sv
`timescale 1ns/1ps
// Clear-on-read event flags; a set in the clearing cycle wins
module brc_sticky #(
  parameter int WIDTH = 1
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             rst,
  // Events, clear strobe and held flags
  input  wire logic [WIDTH-1:0] set,
  input  wire logic             clr,
  output logic      [WIDTH-1:0] flag
);

  genvar i;
  generate
    for (i = 0; i < WIDTH; i++) begin : g_flag
      always_ff @(posedge clk) begin
        if (rst) begin
          flag[i] <= 1'b0;
        end else begin
          flag[i] <= set[i] | (flag[i] & ~clr);
        end
      end
    end
  endgenerate

endmodule : brc_sticky

// ### core/brc_regs.sv
`timescale 1ns/1ps
module brc_regs #(
  parameter int BOOST_CYC = brc_pkg::BOOST_LIM_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst,
  // Register port from the serial control front end
  input  wire logic [7:0]  reg_addr,
  input  wire logic        reg_wr,
  input  wire logic [7:0]  reg_wdata,
  input  wire logic        reg_rd,
  output logic      [7:0]  reg_rdata,
  // Pins
  input  wire logic        enable_pin,
  input  wire logic        bypass_request_pin_n,
  // Analog stage indications, asynchronous
  input  wire logic        thermal_trip_raw,
  input  wire logic        die_hot_raw,
  input  wire logic        pwm_active_raw,
  input  wire logic        switching_raw,
  input  wire logic        bypass_limit_raw,
  input  wire logic        boost_limit_raw,
  input  wire logic        fault_raw,
  input  wire logic        output_ok_raw,
  // Controls to the power stage
  output logic [4:0]       vout_code,
  output logic             limit_disable,
  output logic             soft_start_clamp,
  output logic [3:0]       limit_level,
  output logic [12:0]      limit_ma,
  output logic [12:0]      softstart_ma,
  output logic             level_reserved,
  output logic             force_bypass,
  output logic [1:0]       operation_mode,
  output logic             output_in_range
);

  // Synchronised inputs
  logic [9:0] sync_v;
  logic       en_s;
  logic       byp_n_s;
  logic       thermal_s;
  logic       die_hot_flag;
  logic       modulation_state;
  logic       conversion_state;
  logic       byplim_s;
  logic       bstlim_s;
  logic       fault_s;
  logic       ok_s;

  brc_sync #(
    .WIDTH (10)
  ) u_sync (
    .clk      (clk),
    .rst      (rst),
    .async_in ({enable_pin, bypass_request_pin_n, thermal_trip_raw,
                die_hot_raw, pwm_active_raw, switching_raw,
                bypass_limit_raw, boost_limit_raw, fault_raw,
                output_ok_raw}),
    .sync_out (sync_v)
  );

  // Unpack the clean copies
  assign {en_s, byp_n_s, thermal_s, die_hot_flag, modulation_state,
          conversion_state, byplim_s, bstlim_s, fault_s, ok_s} = sync_v;

  // Address decode
  wire sel_cfg  = (reg_addr == brc_pkg::CONFIG_OFS);
  wire sel_vout = (reg_addr == brc_pkg::VOUT_OFS);
  wire sel_lim  = (reg_addr == brc_pkg::LIMIT_OFS);
  wire sel_stat = (reg_addr == brc_pkg::STATUS_OFS);
  wire wr_cfg   = reg_wr & sel_cfg;
  wire wr_vout  = reg_wr & sel_vout;
  wire wr_lim   = reg_wr & sel_lim;
  wire rd_stat  = reg_rd & sel_stat;

  // Writable registers
  logic [7:0] config_reg;
  logic       soft_start;

  // Configuration register, stored whole
  always_ff @(posedge clk) begin
    if (rst) begin
      config_reg <= brc_pkg::CONFIG_RST;
    end else if (wr_cfg) begin
      config_reg <= reg_wdata;
    end
  end

  // Ceiling code; reserved upper bits are not stored
  always_ff @(posedge clk) begin
    if (rst) begin
      vout_code <= brc_pkg::VOUT_RST;
    end else if (wr_vout) begin
      vout_code <= reg_wdata[brc_pkg::VOUT_W-1:0];
    end
  end

  // Current limit and soft-start register
  always_ff @(posedge clk) begin
    if (rst) begin
      limit_disable <= brc_pkg::LIMOFF_RST;
      soft_start    <= brc_pkg::SOFT_RST;
      limit_level   <= brc_pkg::LEVEL_RST;
    end else if (wr_lim) begin
      limit_disable <= reg_wdata[brc_pkg::LIMOFF_BIT];
      soft_start    <= reg_wdata[brc_pkg::SOFT_BIT];
      limit_level   <= reg_wdata[brc_pkg::LEVEL_W-1:0];
    end
  end

  assign soft_start_clamp = soft_start;

  // Level decode; reserved codes fall back to the reset level so a
  // stray write cannot leave the stage with no sensible limit
  wire [12:0] step_ma   = 13'(brc_pkg::MA_STEP * limit_level[2:0]);
  wire [12:0] level_ma  = 13'(brc_pkg::MA_BASE + step_ma);
  assign level_reserved = ~limit_level[3];
  assign limit_ma       = level_reserved ? brc_pkg::MA_DEFLT
                                         : level_ma;
  assign softstart_ma   = soft_start ? brc_pkg::MA_SOFT
                                     : limit_ma;

  // Forced pass-through only counts while the part is enabled
  assign operation_mode =
    config_reg[brc_pkg::OPER_MSB:brc_pkg::OPER_LSB];
  assign force_bypass   = en_s &
    (operation_mode == brc_pkg::OPER_FORCE_BYPASS);

  // Boost limit must persist before it is reported
  localparam int CNT_W = $clog2(BOOST_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_END = CNT_W'(BOOST_CYC);
  logic [CNT_W-1:0] boost_cnt;
  logic [CNT_W-1:0] next_boost_cnt;
  wire boost_mode  = conversion_state & ~force_bypass;
  wire boost_lim_on = bstlim_s & boost_mode;
  wire boost_hit   = boost_lim_on & (boost_cnt == CNT_END - 1'b1);

  // Saturate so one long episode reports once
  assign next_boost_cnt = !boost_lim_on        ? '0 :
                          (boost_cnt == CNT_END) ? boost_cnt :
                          boost_cnt + 1'b1;

  always_ff @(posedge clk) begin
    if (rst) begin
      boost_cnt <= '0;
    end else begin
      boost_cnt <= next_boost_cnt;
    end
  end

  // Event flags; held while the condition persists (boost limit only until a read), cleared by a read
  logic [3:0] flags;
  brc_sticky #(
    .WIDTH (4)
  ) u_sticky (
    .clk  (clk),
    .rst  (rst),
    .set  ({thermal_s, byplim_s, boost_hit, fault_s}),
    .clr  (rd_stat),
    .flag (flags)
  );

  wire thermal_trip_flag = flags[3];
  wire bypass_limit_flag = flags[2];
  wire boost_limit_flag  = flags[1];
  wire fault_flag        = flags[0];

  // Range indication forced high during pass-through
  assign output_in_range = ok_s | force_bypass;

  // Status image; live bits taken as they stand
  logic [7:0] status_word;
  always_comb begin
    status_word                      = brc_pkg::READ_ZERO;
    status_word[brc_pkg::ST_THERMAL] = thermal_trip_flag;
    status_word[brc_pkg::ST_HOT]     = die_hot_flag;
    status_word[brc_pkg::ST_MODUL]   = modulation_state;
    status_word[brc_pkg::ST_CONV]    = conversion_state;
    status_word[brc_pkg::ST_BYPLIM]  = bypass_limit_flag;
    status_word[brc_pkg::ST_BSTLIM]  = boost_limit_flag;
    status_word[brc_pkg::ST_FAULT]   = fault_flag;
    status_word[brc_pkg::ST_RANGE]   = output_in_range;
  end

  // Read mux; unmapped offsets read zero
  wire [7:0] vout_word = {3'h0, vout_code};
  wire [7:0] lim_word  = {2'h0, limit_disable, soft_start, limit_level};
  wire [7:0] next_rdata = sel_cfg  ? config_reg :
                          sel_vout ? vout_word  :
                          sel_lim  ? lim_word   :
                          sel_stat ? status_word :
                          brc_pkg::READ_ZERO;

  // Read data captured before the clear lands
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= brc_pkg::READ_ZERO;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // Pin kept for a future hardware bypass path; only synchronised now
  wire unused_byp = byp_n_s;

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_write_vout;
    reg_wr && sel_vout;
  endsequence

  AST_VOUT_RESET: assert property (disable iff (1'b0)
    rst |=> (vout_code == brc_pkg::VOUT_RST) && soft_start && !limit_disable)
    else $error("reset values wrong");

  AST_VOUT_WRITE: assert property (
    s_write_vout |=> vout_code == $past(reg_wdata[4:0]))
    else $error("ceiling code not stored");

  AST_VOUT_READBACK: assert property (
    reg_rd && sel_vout |=> reg_rdata[7:5] == 3'h0 &&
      reg_rdata[4:0] == vout_code)
    else $error("ceiling readback wrong");

  AST_LIMIT_OFF: assert property (
    wr_lim |=> limit_disable == $past(reg_wdata[5]))
    else $error("limit disable not stored");

  AST_SOFT_CLAMP: assert property (
    soft_start |-> softstart_ma == brc_pkg::MA_SOFT)
    else $error("soft-start not clamped");

  AST_LEVEL_DEF: assert property (
    wr_lim && reg_wdata[3:0] == 4'hD |=> limit_ma == brc_pkg::MA_DEFLT)
    else $error("default level not 4000 mA");

  AST_LEVEL_TOP: assert property (
    wr_lim && reg_wdata[3:0] == 4'hF |=> limit_ma == 13'h1388)
    else $error("top level not 5000 mA");

  AST_THERMAL_HOLD: assert property (
    thermal_trip_flag && !rd_stat |=> thermal_trip_flag)
    else $error("thermal flag lost without read");

  AST_THERMAL_CLEAR: assert property (
    rd_stat && !thermal_s ##1 !thermal_s |-> !thermal_trip_flag)
    else $error("thermal flag not cleared by read");

  AST_HOT_LIVE: assert property (
    rd_stat |=> reg_rdata[6] == $past(die_hot_flag))
    else $error("hot bit not live");

  AST_MODES_LIVE: assert property (
    rd_stat |=> reg_rdata[5] == $past(modulation_state) &&
      reg_rdata[4] == $past(conversion_state))
    else $error("mode bits not live");

  AST_BYPLIM_HOLD: assert property (
    $rose(byplim_s) |=> bypass_limit_flag [*2] or rd_stat)
    else $error("bypass limit flag not held");

  AST_BOOST_TIME: assert property (
    $rose(boost_limit_flag) |-> $past(boost_cnt) == CNT_END - 1'b1)
    else $error("boost flag set before qualification time");

  AST_FAULT_SET: assert property (
    fault_s |=> fault_flag)
    else $error("fault flag not set");

  AST_RANGE_FORCED: assert property (
    force_bypass |-> output_in_range)
    else $error("range bit low in forced pass-through");

  AST_FORCE: assert property (
    wr_cfg && reg_wdata[6:5] == 2'h2 && en_s ##1 en_s |-> force_bypass)
    else $error("forced pass-through not taken");

  // Bypass limit flag drops once read with the condition gone
  sequence s_byplim_read_quiet;
    rd_stat && !byplim_s;
  endsequence

  AST_BYPLIM_CLEAR: assert property (
    s_byplim_read_quiet |=> !bypass_limit_flag)
    else $error("bypass limit flag not cleared by read");

  AST_LEVEL_RESERVED: assert property (
    level_reserved |-> limit_ma == brc_pkg::MA_DEFLT)
    else $error("reserved level not mapped to 4000 mA");

endmodule : brc_regs

// ### testbench/brc_host.sv
`timescale 1ns/1ps
// Host on the byte register port; one access at a time
module brc_host (
  // Clock
  input  wire logic       clk,
  // Register port
  output logic      [7:0] reg_addr,
  output logic            reg_wr,
  output logic      [7:0] reg_wdata,
  output logic            reg_rd,
  input  wire logic [7:0] reg_rdata
);
  // Idle bus at time zero
  initial begin
    reg_addr  = 8'h00;
    reg_wr    = 1'b0;
    reg_wdata = 8'h00;
    reg_rd    = 1'b0;
  end

  // One-cycle write strobe; idle bus scrambled so stale data never helps
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
    reg_addr  <= ~a;
    reg_wdata <= ~d;
  endtask : wr_reg

  // One-cycle read strobe; data taken after the edge that accepts it
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    reg_addr <= ~a;
    #1;
    d = reg_rdata;
  endtask : rd_reg
endmodule : brc_host

// ### testbench/test_boost_regulator_control_status_regs.sv
`timescale 1ns/1ps
module test_boost_regulator_control_status_regs;
  // Short boost qualification keeps the run brief
  localparam int BOOST = 20;
  logic        clk;
  logic        rst;
  logic        en;
  logic        byp_n;
  logic [7:0]  ev;
  logic [7:0]  addr;
  logic        wr;
  logic [7:0]  wdata;
  logic        rd;
  logic [7:0]  rdata;
  logic [7:0]  got;
  logic [4:0]  vout_code;
  logic        limit_disable;
  logic        soft_clamp;
  logic [3:0]  limit_level;
  logic [12:0] limit_ma;
  logic [12:0] soft_ma;
  logic        level_res;
  logic        force_byp;
  logic [1:0]  op_mode;
  logic        in_range;
  logic [12:0] ma;
  int          err_count;
  int          n_tests;
  int          cyc;

  // Clock and time-zero inputs
  initial clk = 1'b0;
  always #10 clk = ~clk;
  initial begin
    rst       = 1'b1;
    en        = 1'b0;
    byp_n     = 1'b1;
    ev        = 8'h00;
    err_count = 0;
    n_tests   = 0;
    cyc       = 0;
  end

  brc_host host (.clk(clk), .reg_addr(addr), .reg_wr(wr),
    .reg_wdata(wdata), .reg_rd(rd), .reg_rdata(rdata));

  brc_regs #(.BOOST_CYC(BOOST)) uut (.clk(clk), .rst(rst),
    .reg_addr(addr), .reg_wr(wr), .reg_wdata(wdata), .reg_rd(rd),
    .reg_rdata(rdata), .enable_pin(en), .bypass_request_pin_n(byp_n),
    .thermal_trip_raw(ev[7]), .die_hot_raw(ev[6]),
    .pwm_active_raw(ev[5]), .switching_raw(ev[4]),
    .bypass_limit_raw(ev[3]), .boost_limit_raw(ev[2]),
    .fault_raw(ev[1]), .output_ok_raw(ev[0]),
    .vout_code(vout_code), .limit_disable(limit_disable),
    .soft_start_clamp(soft_clamp), .limit_level(limit_level),
    .limit_ma(limit_ma), .softstart_ma(soft_ma),
    .level_reserved(level_res), .force_bypass(force_byp),
    .operation_mode(op_mode), .output_in_range(in_range));

  // Comparison and verdict
  task automatic chk(input string nm, input logic [12:0] seen,
                     input logic [12:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : tally_and_finish

  task automatic rdchk(input logic [7:0] a, input logic [7:0] exp);
    host.rd_reg(a, got);
    chk("reg_rdata", 13'(got), 13'(exp));
  endtask : rdchk

  // Waits end just past the edge so updates have landed
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : waitc

  task automatic setev(input logic [7:0] v);
    @(posedge clk);
    ev <= v;
  endtask : setev

  // Hang guard, well above the expected few hundred cycles
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      err_count++;
      tally_and_finish();
    end
  end

  initial begin
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    waitc(6);
    // Reset contents, reserved and unmapped places
    rdchk(brc_pkg::VOUT_OFS, 8'h0B);
    rdchk(brc_pkg::LIMIT_OFS, 8'h1D);
    rdchk(brc_pkg::STATUS_OFS, 8'h00);
    rdchk(brc_pkg::CONFIG_OFS, 8'h09);
    rdchk(8'h10, 8'h00);
    chk("limit_ma", limit_ma, 13'h0FA0);
    chk("softstart_ma", soft_ma, 13'h04E2);
    chk("limit_disable", 13'(limit_disable), 13'h0000);
    host.wr_reg(brc_pkg::VOUT_OFS, 8'hFF);
    rdchk(brc_pkg::VOUT_OFS, 8'h1F);
    chk("vout_code", 13'(vout_code), 13'h001F);
    host.wr_reg(brc_pkg::STATUS_OFS, 8'hFF);
    rdchk(brc_pkg::STATUS_OFS, 8'h00);
    // Every level code, soft-start off so it follows the level
    for (int c = 0; c < 16; c++) begin
      host.wr_reg(brc_pkg::LIMIT_OFS, 8'(c));
      waitc(1);
      ma = (c >= 8) ? 13'(1500 + 500 * (c - 8)) : 13'h0FA0;
      chk("limit_ma", limit_ma, ma);
      chk("softstart_ma", soft_ma, ma);
      chk("level_reserved", 13'(level_res), 13'(c < 8));
      chk("limit_level", 13'(limit_level), 13'(c));
    end
    host.wr_reg(brc_pkg::LIMIT_OFS, 8'hFF);
    waitc(1);
    chk("limit_disable", 13'(limit_disable), 13'h0001);
    chk("softstart_ma", soft_ma, 13'h04E2);
    chk("soft_start_clamp", 13'(soft_clamp), 13'h0001);
    rdchk(brc_pkg::LIMIT_OFS, 8'h3F);
    // Mid-run reset brings the written registers back to defaults
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    waitc(6);
    rdchk(brc_pkg::VOUT_OFS, 8'h0B);
    rdchk(brc_pkg::LIMIT_OFS, 8'h1D);
    // Live bits follow; event bits hold until a read clears them
    for (int b = 0; b < 8; b++) begin
      if (b != 2) begin
        setev(8'h01 << b);
        waitc(6);
        rdchk(brc_pkg::STATUS_OFS, 8'h01 << b);
        setev(8'h00);
        waitc(6);
        rdchk(brc_pkg::STATUS_OFS, (8'h01 << b) & 8'h8A);
        rdchk(brc_pkg::STATUS_OFS, 8'h00);
      end
    end
    // Boost limit broken before the count runs out never flags
    for (int i = 0; i < 2; i++) begin
      setev(8'h14);
      waitc(12);
      setev(8'h10);
      waitc(6);
    end
    rdchk(brc_pkg::STATUS_OFS, 8'h10);
    setev(8'h14);
    waitc(BOOST + 12);
    setev(8'h10);
    waitc(6);
    rdchk(brc_pkg::STATUS_OFS, 8'h14);
    rdchk(brc_pkg::STATUS_OFS, 8'h10);
    setev(8'h00);
    // Forced pass-through only while enabled; bypass pin must not matter
    en    <= 1'b1;
    byp_n <= 1'b0;
    host.wr_reg(brc_pkg::CONFIG_OFS, 8'h49);
    waitc(6);
    chk("force_bypass", 13'(force_byp), 13'h0001);
    chk("operation_mode", 13'(op_mode), 13'h0002);
    chk("output_in_range", 13'(in_range), 13'h0001);
    rdchk(brc_pkg::STATUS_OFS, 8'h01);
    rdchk(brc_pkg::CONFIG_OFS, 8'h49);
    @(posedge clk);
    en    <= 1'b0;
    byp_n <= 1'b1;
    waitc(6);
    chk("force_bypass", 13'(force_byp), 13'h0000);
    chk("output_in_range", 13'(in_range), 13'h0000);
    tally_and_finish();
  end
endmodule : test_boost_regulator_control_status_regs
